// [pkg/cpcmc_consts.vh]
/*
  Register offsets, field positions, reset values and encodings of the CPU and
  peripheral clock mode controller. Definitions only.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CPCMC_CONSTS_VH
`define CPCMC_CONSTS_VH

// Byte offsets on the Avalon-MM register port
`define CPCMC_ADDR_CTRL0        5'h00
`define CPCMC_ADDR_CTRL1        5'h04
`define CPCMC_ADDR_CTRL2        5'h08
`define CPCMC_ADDR_PMODE        5'h0c
`define CPCMC_ADDR_STATUS       5'h10

// system_clock_control0 fields
`define CPCMC_C0_CLOCK_OUTPUT_PIN_LO      0
`define CPCMC_C0_CLOCK_OUTPUT_PIN_HI      1
`define CPCMC_C0_STOP_IN_WAIT   2
`define CPCMC_C0_SUB_ENABLE     4
`define CPCMC_C0_MAIN_STOP      5
`define CPCMC_C0_DIV8           6
`define CPCMC_C0_SUB_SELECT     7
`define CPCMC_C0_RESET          8'h40

// system_clock_control1 fields
`define CPCMC_C1_PLL_SELECT     1
`define CPCMC_C1_ONCHIP_STOP    4
`define CPCMC_C1_DIV_LO         6
`define CPCMC_C1_DIV_HI         7
`define CPCMC_C1_RESET          8'h00

// oscillation_detect_control fields
`define CPCMC_C2_PERIPH_ONCHIP  1
`define CPCMC_C2_RESET          8'h02

// processor_mode_control0 fields
`define CPCMC_PM_MODE_LO        0
`define CPCMC_PM_MODE_HI        1
`define CPCMC_PM_BCLK_DISABLE   7
`define CPCMC_PM_RESET          8'h00
`define CPCMC_PM_SINGLE_CHIP    2'h0

// Clock output select codes
`define CPCMC_CO_PORT           2'h0
`define CPCMC_CO_SUB            2'h1
`define CPCMC_CO_DIV8           2'h2
`define CPCMC_CO_DIV32          2'h3

// Normal operating sub-modes, one-hot in the status register
`define CPCMC_M_PLL             7'h01
`define CPCMC_M_HIGH            7'h02
`define CPCMC_M_MEDIUM          7'h04
`define CPCMC_M_LOW             7'h08
`define CPCMC_M_LOWPWR          7'h10
`define CPCMC_M_ONCHIP          7'h20
`define CPCMC_M_ONCHIP_LP       7'h40

// Peripheral prescaler taps
`define CPCMC_TAP8_LAST         5'h07
`define CPCMC_TAP32_LAST        5'h1f

`endif

// [src/cpcmc_clock_mode_control.v]
/*
  CPU clock selection, divider, peripheral clock derivation, clock output
  and power-mode sequencing, with an Avalon-MM register slave.
  Assumes every oscillator is presented as a one-cycle tick synchronous to
  sys_clk, and that the CPU signals wait and stop as synchronous levels.
  Every derived clock but the bus clock pin, which idles high in wait, leaves as a one-cycle enable pulse on sys_clk.
*/
// The register offsets and the Avalon-MM register port were decided locally.
// Notes on behaviour
// - CPU source: main, sub, on-chip, PLL
// - Main, PLL, on-chip divided by 1-16
// - Reset: on-chip oscillator divided by eight
// - Bus clock out in expansion modes
// - Force divide-by-8 on stop, low-power entry
// - Main peripheral clock from main, PLL, on-chip
// - Gate peripheral clock: wait option, low power
// - Sub timer clock only while sub runs
// - On-chip timer clock only while running
// - Single-chip clock output: div8, div32, sub
// - Normal, wait, stop; seven normal sub-modes
// - High-speed: undivided main clock
// - Medium-speed: main divided by 2-16
// - Low-speed: sub CPU, selectable peripheral source
// - Main stop in low-speed enters low power
// - On-chip mode: divided CPU, on-chip peripherals
// - Wait stops CPU clock, oscillators keep running
`timescale 1ns/100ps
`default_nettype none
`include "cpcmc_consts.vh"

module cpcmc_clock_mode_control #(
    parameter DIV_W = 4
) (
    input  wire         sys_clk,
    input  wire         rst,
    input  wire [4:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    output reg  [31:0]  avs_readdata,
    output reg          avs_waitrequest,
    input  wire         main_osc_tick,
    input  wire         sub_osc_tick,
    input  wire         onchip_osc_tick,
    input  wire         pll_tick,
    input  wire         wait_mode,
    input  wire         stop_mode,
    output reg          cpu_clock_en,
    output reg          bus_clock_pin,
    output reg          clock_output_pin,
    output reg          main_periph_clock,
    output reg          periph_div8_tap,
    output reg          periph_div32_tap,
    output reg          sub_timer_clock,
    output reg          onchip_timer_clock
);

    localparam SRC_MAIN   = 4'b0001;
    localparam SRC_SUB    = 4'b0010;
    localparam SRC_ONCHIP = 4'b0100;
    localparam SRC_PLL    = 4'b1000;

    reg  [7:0]       system_clock_control0;
    reg  [7:0]       system_clock_control1;
    reg  [7:0]       oscillation_detect_control;
    reg  [7:0]       processor_mode_control0;

    wire clock_output_pin_select_lo         = system_clock_control0[`CPCMC_C0_CLOCK_OUTPUT_PIN_LO];
    wire clock_output_pin_select_hi         = system_clock_control0[`CPCMC_C0_CLOCK_OUTPUT_PIN_HI];
    wire periph_clk_stop_in_wait  = system_clock_control0[`CPCMC_C0_STOP_IN_WAIT];
    wire sub_osc_enable           = system_clock_control0[`CPCMC_C0_SUB_ENABLE];
    wire main_osc_stop            = system_clock_control0[`CPCMC_C0_MAIN_STOP];
    wire cpu_div8_select          = system_clock_control0[`CPCMC_C0_DIV8];
    wire cpu_sub_select           = system_clock_control0[`CPCMC_C0_SUB_SELECT];
    wire pll_cpu_select           = system_clock_control1[`CPCMC_C1_PLL_SELECT];
    wire onchip_osc_stop          = system_clock_control1[`CPCMC_C1_ONCHIP_STOP];
    wire cpu_div_field_lo         = system_clock_control1[`CPCMC_C1_DIV_LO];
    wire cpu_div_field_hi         = system_clock_control1[`CPCMC_C1_DIV_HI];
    wire periph_src_onchip_select = oscillation_detect_control[`CPCMC_C2_PERIPH_ONCHIP];
    wire bus_clock_output_disable = processor_mode_control0[`CPCMC_PM_BCLK_DISABLE];
    wire [1:0] proc_mode = {processor_mode_control0[`CPCMC_PM_MODE_HI],
                            processor_mode_control0[`CPCMC_PM_MODE_LO]};
    wire single_chip = (proc_mode == `CPCMC_PM_SINGLE_CHIP);

    // Divide ratio minus one: the divide-by-8 bit overrides the two-bit field
    function [DIV_W-1:0] div_last;
        input d8;
        input [1:0] fld;
        begin
            if (d8) begin
                div_last = 4'd7;
            end else begin
                case (fld)
                    2'h0:    div_last = 4'd0;
                    2'h1:    div_last = 4'd1;
                    2'h2:    div_last = 4'd3;
                    default: div_last = 4'd15;
                endcase
            end
        end
    endfunction

    // Classifies the control bits into the seven normal sub-modes
    function [6:0] mode_of;
        input sub_sel;
        input pll_sel;
        input onchip_sel;
        input main_stop;
        input [DIV_W-1:0] dl;
        begin
            if (sub_sel) begin
                mode_of = main_stop ? `CPCMC_M_LOWPWR : `CPCMC_M_LOW;
            end else if (onchip_sel) begin
                mode_of = main_stop ? `CPCMC_M_ONCHIP_LP : `CPCMC_M_ONCHIP;
            end else if (pll_sel) begin
                mode_of = `CPCMC_M_PLL;
            end else if (dl == 4'd0) begin
                mode_of = `CPCMC_M_HIGH;
            end else begin
                mode_of = `CPCMC_M_MEDIUM;
            end
        end
    endfunction

    // Oscillators as seen by the logic: off in stop mode or when disabled
    wire main_run   = !main_osc_stop && !stop_mode;
    wire sub_run    = sub_osc_enable && !stop_mode;
    wire onchip_run = !onchip_osc_stop && !stop_mode;
    wire main_t     = main_osc_tick && main_run;
    wire sub_t      = sub_osc_tick && sub_run;
    wire onchip_t   = onchip_osc_tick && onchip_run;
    wire pll_t      = pll_tick && main_run;

    wire [DIV_W-1:0] cur_div_last = div_last(cpu_div8_select, {cpu_div_field_hi, cpu_div_field_lo});
    wire [6:0] cur_mode = mode_of(cpu_sub_select, pll_cpu_select, periph_src_onchip_select,
                                  main_osc_stop, cur_div_last);

    reg [3:0] next_cpu_src;
    always @* begin
        if (cpu_sub_select) begin
            next_cpu_src = SRC_SUB;
        end else if (periph_src_onchip_select) begin
            next_cpu_src = SRC_ONCHIP;
        end else if (pll_cpu_select) begin
            next_cpu_src = SRC_PLL;
        end else begin
            next_cpu_src = SRC_MAIN;
        end
    end

    reg cpu_src_tick;
    always @* begin
        case (next_cpu_src)
            SRC_MAIN:   cpu_src_tick = main_t;
            SRC_SUB:    cpu_src_tick = sub_t;
            SRC_ONCHIP: cpu_src_tick = onchip_t;
            SRC_PLL:    cpu_src_tick = pll_t;
            default:    cpu_src_tick = 1'b0;
        endcase
    end

    // Sub clock is never divided; other sources use the programmed ratio
    wire [DIV_W-1:0] eff_div_last = next_cpu_src[1] ? {DIV_W{1'b0}} : cur_div_last;

    // Peripheral source: on-chip in on-chip modes or when low-speed picks it
    reg periph_src_tick;
    always @* begin
        if (periph_src_onchip_select) begin
            periph_src_tick = onchip_t;
        end else if (pll_cpu_select) begin
            periph_src_tick = pll_t;
        end else begin
            periph_src_tick = main_t;
        end
    end

    wire low_power = (cur_mode == `CPCMC_M_LOWPWR);
    wire periph_gate_off = stop_mode || low_power || (wait_mode && periph_clk_stop_in_wait);

    // Bus handshake: one wait state, then the access completes
    wire bus_req   = avs_read || avs_write;
    wire bus_take  = bus_req && !avs_waitrequest;
    wire wr_take   = avs_write && !avs_waitrequest;
    reg  stop_q;
    // Stop entry is an edge, so the divide-by-8 bit is forced once per stop
    // and is not held against software for the whole stop
    wire stop_entry = stop_mode && !stop_q;
    // Low power entry needs sub select both before and after the write
    wire lp_entry   = wr_take && (avs_address == `CPCMC_ADDR_CTRL0) && cpu_sub_select
                      && !main_osc_stop && avs_writedata[`CPCMC_C0_MAIN_STOP]
                      && avs_writedata[`CPCMC_C0_SUB_SELECT];

    always @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            // Read data is latched in the wait state, before the request is taken, and stands in the answer cycle
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `CPCMC_ADDR_CTRL0:  avs_readdata <= {24'h000000, system_clock_control0};
                    `CPCMC_ADDR_CTRL1:  avs_readdata <= {24'h000000, system_clock_control1};
                    `CPCMC_ADDR_CTRL2:  avs_readdata <= {24'h000000, oscillation_detect_control};
                    `CPCMC_ADDR_PMODE:  avs_readdata <= {24'h000000, processor_mode_control0};
                    `CPCMC_ADDR_STATUS: avs_readdata <= {22'h0, stop_mode, wait_mode,
                                                         1'b0, cur_mode};
                    default:            avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Registers; hardware forcing of divide-by-8 wins over a software write
    always @(posedge sys_clk) begin
        if (rst) begin
            system_clock_control0      <= `CPCMC_C0_RESET;
            system_clock_control1      <= `CPCMC_C1_RESET;
            oscillation_detect_control <= `CPCMC_C2_RESET;
            processor_mode_control0    <= `CPCMC_PM_RESET;
            stop_q                     <= 1'b0;
        end else begin
            stop_q <= stop_mode;
            if (wr_take) begin
                case (avs_address)
                    `CPCMC_ADDR_CTRL0: system_clock_control0      <= avs_writedata[7:0];
                    `CPCMC_ADDR_CTRL1: system_clock_control1      <= avs_writedata[7:0];
                    `CPCMC_ADDR_CTRL2: oscillation_detect_control <= avs_writedata[7:0];
                    `CPCMC_ADDR_PMODE: processor_mode_control0    <= avs_writedata[7:0];
                    default: ;
                endcase
            end
            if (stop_entry || lp_entry) begin
                system_clock_control0[`CPCMC_C0_DIV8] <= 1'b1;
            end
        end
    end

    // CPU divider: a change of source or ratio restarts the count, so the
    // first enable after it is a full period of the new setting
    reg [3:0]       cpu_src_q;
    reg [DIV_W-1:0] div_last_q;
    reg [DIV_W-1:0] cpu_cnt;
    wire sel_change = (cpu_src_q != next_cpu_src) || (div_last_q != eff_div_last);

    always @(posedge sys_clk) begin
        if (rst) begin
            cpu_src_q    <= SRC_ONCHIP;
            div_last_q   <= 4'd7;
            cpu_cnt      <= 4'd0;
            cpu_clock_en <= 1'b0;
        end else begin
            cpu_src_q    <= next_cpu_src;
            div_last_q   <= eff_div_last;
            cpu_clock_en <= 1'b0;
            // The count keeps running in wait, so waking keeps the period
            if (sel_change) begin
                cpu_cnt <= 4'd0;
            end else if (cpu_src_tick) begin
                if (cpu_cnt >= div_last_q) begin
                    cpu_cnt      <= 4'd0;
                    cpu_clock_en <= !wait_mode && !stop_mode;
                end else begin
                    cpu_cnt <= cpu_cnt + 4'd1;
                end
            end
        end
    end

    // Bus clock follows the CPU enable; it idles high in wait mode
    always @(posedge sys_clk) begin
        if (rst) begin
            bus_clock_pin <= 1'b0;
        end else if (single_chip || bus_clock_output_disable) begin
            bus_clock_pin <= 1'b0;
        end else if (wait_mode) begin
            bus_clock_pin <= 1'b1;
        end else begin
            bus_clock_pin <= cpu_src_tick && !sel_change && (cpu_cnt >= div_last_q) && !stop_mode;
        end
    end

    // Peripheral clock, prescaler taps and timer clocks
    reg [4:0] pre_cnt;
    reg [4:0] sub_cnt;
    wire f1_tick = periph_src_tick && !periph_gate_off;
    // Taps count events of the gated clock, so they pause with it
    wire tap8    = f1_tick && ({2'b00, pre_cnt[2:0]} == `CPCMC_TAP8_LAST);
    wire tap32   = f1_tick && (pre_cnt == `CPCMC_TAP32_LAST);

    always @(posedge sys_clk) begin
        if (rst) begin
            pre_cnt            <= 5'h00;
            sub_cnt            <= 5'h00;
            main_periph_clock  <= 1'b0;
            periph_div8_tap    <= 1'b0;
            periph_div32_tap   <= 1'b0;
            sub_timer_clock    <= 1'b0;
            onchip_timer_clock <= 1'b0;
        end else begin
            if (f1_tick) begin
                pre_cnt <= pre_cnt + 5'h01;
            end
            if (sub_t) begin
                sub_cnt <= sub_cnt + 5'h01;
            end
            main_periph_clock  <= f1_tick;
            periph_div8_tap    <= tap8;
            periph_div32_tap   <= tap32;
            // Timer clocks ignore the wait gating of the main peripheral clock
            sub_timer_clock    <= sub_t && (sub_cnt == `CPCMC_TAP32_LAST);
            onchip_timer_clock <= onchip_t;
        end
    end

    // Clock output only in single-chip mode; select 0 leaves the pin low
    // The pin carries enable pulses, not a square wave
    reg next_clock_output_pin;
    always @* begin
        case ({clock_output_pin_select_hi, clock_output_pin_select_lo})
            `CPCMC_CO_SUB:   next_clock_output_pin = sub_t;
            `CPCMC_CO_DIV8:  next_clock_output_pin = tap8;
            `CPCMC_CO_DIV32: next_clock_output_pin = tap32;
            default:         next_clock_output_pin = 1'b0;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            clock_output_pin <= 1'b0;
        end else begin
            clock_output_pin <= single_chip && next_clock_output_pin;
        end
    end

endmodule  // cpcmc_clock_mode_control

`default_nettype wire

// [testbench/cpcmc_assertions.sv]
/*
  Checker of the clock mode controller: register handshake and clock pulse causes.
  Assumes it is bound into cpcmc_clock_mode_control and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module cpcmc_checker (
    input wire sys_clk,
    input wire rst,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire main_osc_tick,
    input wire sub_osc_tick,
    input wire onchip_osc_tick,
    input wire pll_tick,
    input wire wait_mode,
    input wire stop_mode,
    input wire cpu_clock_en,
    input wire bus_clock_pin,
    input wire clock_output_pin,
    input wire main_periph_clock,
    input wire periph_div8_tap,
    input wire sub_timer_clock,
    input wire onchip_timer_clock
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered after one wait state");
    property p_release; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_release: assert property (p_release) else $error("waitrequest low for more than one cycle");
    property p_cpu_src; cpu_clock_en |-> $past(main_osc_tick || sub_osc_tick || onchip_osc_tick || pll_tick); endproperty
    a_cpu_src: assert property (p_cpu_src) else $error("cpu pulse without a source tick");
    property p_cpu_hold; wait_mode || stop_mode |=> !cpu_clock_en; endproperty
    a_cpu_hold: assert property (p_cpu_hold) else $error("cpu pulse in wait or stop");
    property p_stop_quiet; stop_mode |=> !main_periph_clock && !sub_timer_clock && !onchip_timer_clock; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("peripheral pulse in stop");
    property p_periph_src; main_periph_clock |-> $past(main_osc_tick || pll_tick || onchip_osc_tick); endproperty
    a_periph_src: assert property (p_periph_src) else $error("peripheral pulse without a source tick");
    property p_sub_tmr; sub_timer_clock |-> $past(sub_osc_tick); endproperty
    a_sub_tmr: assert property (p_sub_tmr) else $error("sub timer pulse without a sub tick");
    property p_on_tmr; onchip_timer_clock |-> $past(onchip_osc_tick); endproperty
    a_on_tmr: assert property (p_on_tmr) else $error("on-chip timer pulse without a tick");
    property p_pins; !(clock_output_pin && bus_clock_pin); endproperty
    a_pins: assert property (p_pins) else $error("clock output and bus clock active together");
    // Eight peripheral events need at least eight cycles
    property p_tap8; periph_div8_tap |=> !periph_div8_tap [*7]; endproperty
    a_tap8: assert property (p_tap8) else $error("divide-by-8 tap repeats too soon");
    c_cpu: cover property (cpu_clock_en);
    c_bus: cover property (bus_clock_pin);
    c_clock_output_pin: cover property (clock_output_pin);
    c_sub: cover property (sub_timer_clock);
endmodule // cpcmc_checker
bind cpcmc_clock_mode_control cpcmc_checker u_chk (.sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .main_osc_tick(main_osc_tick),
    .sub_osc_tick(sub_osc_tick), .onchip_osc_tick(onchip_osc_tick), .pll_tick(pll_tick),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .cpu_clock_en(cpu_clock_en),
    .bus_clock_pin(bus_clock_pin), .clock_output_pin(clock_output_pin),
    .main_periph_clock(main_periph_clock), .periph_div8_tap(periph_div8_tap),
    .sub_timer_clock(sub_timer_clock), .onchip_timer_clock(onchip_timer_clock));
`default_nettype wire

// [testbench/tb_cpu_periph_clock_mode_control.sv]
/*
  Self-checking bench of the clock mode controller: registers over Avalon-MM, pulse rates per mode.
  Assumes the controller and its bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_periph_clock_mode_control;
    logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, wait_mode = 0, stop_mode = 0;
    logic        main_osc_tick = 0, sub_osc_tick = 0, onchip_osc_tick = 0, pll_tick = 0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, q;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, cpu_clock_en, bus_clock_pin, clock_output_pin, main_periph_clock;
    wire         periph_div8_tap, periph_div32_tap, sub_timer_clock, onchip_timer_clock;
    int          num_errors = 0, check_count = 0, ph = 0, r, dv;
    int          cnt[12], s[12], d[12];
    // Index 0-3 source ticks, 4 cpu, 5 bus, 6 clock_output_pin, 7 periph, 8-9 taps, 10-11 timers
    wire  [11:0] v = {onchip_timer_clock, sub_timer_clock, periph_div32_tap, periph_div8_tap, main_periph_clock,
                      clock_output_pin, bus_clock_pin, cpu_clock_en, pll_tick, onchip_osc_tick, sub_osc_tick,
                      main_osc_tick};
    cpcmc_clock_mode_control dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .main_osc_tick(main_osc_tick),
        .sub_osc_tick(sub_osc_tick), .onchip_osc_tick(onchip_osc_tick), .pll_tick(pll_tick),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .cpu_clock_en(cpu_clock_en),
        .bus_clock_pin(bus_clock_pin), .clock_output_pin(clock_output_pin),
        .main_periph_clock(main_periph_clock), .periph_div8_tap(periph_div8_tap),
        .periph_div32_tap(periph_div32_tap), .sub_timer_clock(sub_timer_clock),
        .onchip_timer_clock(onchip_timer_clock));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Distinct tick periods so every source can be told apart by its rate
    always @(posedge sys_clk) begin
        ph <= ph + 1;
        main_osc_tick <= ph % 2 == 0;
        sub_osc_tick <= ph % 5 == 0;
        onchip_osc_tick <= ph % 3 == 1;
        pll_tick <= ph % 4 == 3;
        for (int i = 0; i < 12; i++) cnt[i] <= cnt[i] + v[i];
    end
    task summarize;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Pulse counts allow one of slack for the output lag, except where none may appear
    task rate(input string n, input int e, input int g);
        check_count++;
        if (e == 0 ? g != 0 : (g > e + 1 || g < e - 1)) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task xfer(input logic w, input logic [4:0] a, input logic [7:0] dd);
        logic [31:0] x;
        x = $urandom;
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {x[23:0], dd};
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task rd(input string n, input logic [4:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00);
        chk(n, e, q);
    endtask
    task ms;
        repeat (4) @(posedge sys_clk);
        s = cnt;
        repeat (960) @(posedge sys_clk);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask
    // Control 0 goes first so divide-by-8 is set before any source change
    task cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] pm);
        xfer(1'b1, 5'h00, c0);
        xfer(1'b1, 5'h04, c1);
        xfer(1'b1, 5'h08, c2);
        xfer(1'b1, 5'h0c, pm);
        ms;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        summarize;
    end
    initial begin
        r = $urandom(32'h0fcfa911);
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd("ctrl0", 5'h00, 32'h40);
        rd("ctrl1", 5'h04, 32'h00);
        rd("ctrl2", 5'h08, 32'h02);
        rd("pmode", 5'h0c, 32'h00);
        rd("status", 5'h10, 32'h20);
        xfer(1'b1, 5'h14, 8'hff);
        rd("unmapped", 5'h14, 32'h00);
        rd("ctrl0", 5'h00, 32'h40);
        ms;
        rate("cpu", d[2] / 8, d[4]);
        rate("onchip timer", d[2], d[11]);
        rate("periph", d[2], d[7]);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            dv = (i == 4) ? 8 : (i == 3 ? 16 : 1 << i);
            cfg(i == 4 ? 8'h40 : 8'h00, i == 4 ? 8'h00 : 8'(i << 6), 8'h02, 8'h00);
            rate("cpu", d[2] / dv, d[4]);
        end
        // Main stopped while on the on-chip oscillator: on-chip low power mode
        cfg(8'h20, 8'h00, 8'h02, 8'h00);
        rd("status", 5'h10, 32'h40);
        rate("cpu", d[2], d[4]);
        rate("periph", d[2], d[7]);
        $display("test onchip divider done");
        cfg(8'h40, 8'h00, 8'h00, 8'h00);
        rd("status", 5'h10, 32'h04);
        rate("cpu", d[0] / 8, d[4]);
        rate("periph", d[0], d[7]);
        r = 1 + $urandom % 3;
        dv = (r == 3) ? 16 : 1 << r;
        cfg(8'h00, 8'(r << 6), 8'h00, 8'h00);
        rate("cpu", d[0] / dv, d[4]);
        cfg(8'h00, 8'h10, 8'h00, 8'h00);
        rd("status", 5'h10, 32'h02);
        rate("cpu", d[0], d[4]);
        rate("onchip timer", 0, d[11]);
        cfg(8'h00, 8'h02, 8'h00, 8'h00);
        rd("status", 5'h10, 32'h01);
        rate("cpu", d[3], d[4]);
        $display("test main and pll done");
        for (int k = 1; k < 4; k++) begin
            cfg(8'(8'h10 | k), 8'h00, 8'h00, 8'h00);
            rate("clock_output_pin", k == 1 ? d[1] : (k == 2 ? d[7] / 8 : d[7] / 32), d[6]);
        end
        rate("div8 tap", d[7] / 8, d[8]);
        rate("div32 tap", d[7] / 32, d[9]);
        rate("sub timer", d[1] / 32, d[10]);
        $display("test clock output done");
        r = 1 + $urandom % 3;
        cfg(8'h03, 8'h00, 8'h00, 8'(r));
        rate("bus clock", d[4], d[5]);
        rate("clock_output_pin", 0, d[6]);
        rate("sub timer", 0, d[10]);
        cfg(8'h04, 8'h00, 8'h00, 8'(8'h80 | r));
        rate("bus clock", 0, d[5]);
        // Bus clock enabled again so the pin must idle high through wait
        xfer(1'b1, 5'h0c, 8'(r));
        wait_mode <= 1'b1;
        ms;
        rate("cpu", 0, d[4]);
        rate("periph", 0, d[7]);
        rate("onchip timer", d[2], d[11]);
        chk("bus pin", 32'h1, {31'h0, bus_clock_pin});
        rd("status", 5'h10, 32'h102);
        wait_mode <= 1'b0;
        $display("test wait done");
        cfg(8'h10, 8'h00, 8'h00, 8'h00);
        cfg(8'h90, 8'h00, 8'h02, 8'h00);
        rd("status", 5'h10, 32'h08);
        rate("cpu", d[1], d[4]);
        rate("periph", d[2], d[7]);
        cfg(8'h90, 8'h00, 8'h00, 8'h00);
        rate("periph", d[0], d[7]);
        cfg(8'hb0, 8'h00, 8'h00, 8'h00);
        rd("ctrl0", 5'h00, 32'hf0);
        rd("status", 5'h10, 32'h10);
        rate("cpu", d[1], d[4]);
        rate("periph", 0, d[7]);
        $display("test low power done");
        xfer(1'b1, 5'h00, 8'hd0);
        cfg(8'h50, 8'h00, 8'h00, 8'h00);
        rd("status", 5'h10, 32'h04);
        cfg(8'h10, 8'h00, 8'h00, 8'h00);
        stop_mode <= 1'b1;
        ms;
        rd("ctrl0", 5'h00, 32'h50);
        rate("cpu", 0, d[4]);
        rate("periph", 0, d[7]);
        stop_mode <= 1'b0;
        $display("test stop done");
        summarize;
    end
endmodule // tb_cpu_periph_clock_mode_control
`default_nettype wire
